// file: switch_ctrl_top.sv
// Behaviour
// - Frames carry a 16-bit command in and 16-bit status out, MSB first.
// - Commands apply only on the rising chip-select edge.
// - Command bits 0-7 switch channels one to eight on or off.
// - Command bits 8-15 enable open-load detection current per channel.
// - Status bits 8-15 always read zero.
// - Status bits 0-7 flag a fault on channels one to eight.
// - Open load reported only when off and detection current enabled.
// - Over-current or short to supply sets the channel status bit.
// - Over-temperature switches off that channel only, recovering when cooled.
// - Supply over-voltage forces all off; commanded state resumes after.
// - Logic supply over-voltage is not monitored.
// - Enable low or logic supply loss enters sleep.
// - Sleep resets command state: all off, detection currents off.
// - Status shifts out on the same clocks as the command shifts in.
// - No faults with detection enabled gives all-zero status.
// - 32-bit frame echoes the first half; last 16 bits become command.
// - Only frames of 16 plus a multiple of 8 pulses are accepted.
// - Input sampled on falling, output advanced on rising serial clock edges.
// - With chip select high, clock and input ignored, output released.
// - Channels five and six also turn on from direct-drive inputs.
// - Shift path is FIFO: input appears at output after 16 clocks.
/*
  Top of the octal switch serial control block: command register, fault
  status and protection gating on ref_clk_in. Assumes analog sensors arrive as
  asynchronous levels and the host drives chip select and the serial clock.
*/
`timescale 1ns/1ps
module switch_ctrl_top
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic serial_in,
  input wire logic enable_in,
  input wire logic logic_supply_ok_in,
  input wire logic supply_overvolt_level_in,
  input wire logic direct_drive_ch5_in,
  input wire logic direct_drive_ch6_in,
  input wire logic [switch_ctrl_pkg::CHANNELS-1:0] thermal_limit_in,
  input wire logic [switch_ctrl_pkg::CHANNELS-1:0] overcurrent_in,
  input wire logic [switch_ctrl_pkg::CHANNELS-1:0] open_load_in,
  output logic serial_out,
  output logic serial_oe_n_out,
  output logic [switch_ctrl_pkg::CHANNELS-1:0] channel_on_out,
  output logic [switch_ctrl_pkg::CHANNELS-1:0] detect_current_on_out,
  output logic sleep_out
);
  import switch_ctrl_pkg::*;

  // ----------------------------------------------------------------------
  // Serial link on the host clock
  // ----------------------------------------------------------------------
  logic [15:0] rx_word;
  logic [5:0] pulse_count;
  logic [15:0] fault_word_reg;
  logic [15:0] fault_word_next;
  logic link_out;
  logic link_oe_n;

  serial_shift_link u_link
  (
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .serial_in(serial_in),
    .status_word_in(fault_word_reg),
    .serial_out(link_out),
    .serial_oe_n_out(link_oe_n),
    .rx_word_out(rx_word),
    .pulse_count_out(pulse_count)
  );

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  // The received word and pulse count are stable while chip select is high,
  // so they are captured only after the synchronised rising edge is seen.
  localparam int SYNC_W = 4 + 3 * CHANNELS;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic cs_seen_reg;

  always_ff @(posedge ref_clk_in)
  begin
    sync1_reg <= {cs_n_in, enable_in, logic_supply_ok_in, supply_overvolt_level_in,
                  thermal_limit_in, overcurrent_in, open_load_in};
    sync2_reg <= sync1_reg;
  end

  logic cs_n_s;
  logic en_s;
  logic vdd_ok_s;
  logic ov_s;
  logic [CHANNELS-1:0] thermal_limit_s;
  logic [CHANNELS-1:0] oc_s;
  logic [CHANNELS-1:0] ol_s;
  logic dd5_s1;
  logic dd5_s2;
  logic dd6_s1;
  logic dd6_s2;

  assign {cs_n_s, en_s, vdd_ok_s, ov_s} = sync2_reg[SYNC_W-1:SYNC_W-4];
  assign thermal_limit_s = sync2_reg[3*CHANNELS-1:2*CHANNELS];
  assign oc_s = sync2_reg[2*CHANNELS-1:CHANNELS];
  assign ol_s = sync2_reg[CHANNELS-1:0];

  always_ff @(posedge ref_clk_in)
  begin
    dd5_s1 <= direct_drive_ch5_in;
    dd5_s2 <= dd5_s1;
    dd6_s1 <= direct_drive_ch6_in;
    dd6_s2 <= dd6_s1;
  end

  // ----------------------------------------------------------------------
  // Command register and fault status
  // ----------------------------------------------------------------------
  function automatic logic frame_ok(input logic [5:0] n);
    frame_ok = (n >= MIN_PULSES) && (n[2:0] == 3'h0) && (n != PULSE_LIMIT);
  endfunction

  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  logic sleep_reg;
  logic sleep_next;
  logic [CHANNELS-1:0] on_reg;
  logic [CHANNELS-1:0] on_next;
  logic [CHANNELS-1:0] det_reg;
  logic [CHANNELS-1:0] det_next;
  logic out_reg;
  logic oe_n_reg;
  logic [CHANNELS-1:0] drive;
  logic [CHANNELS-1:0] fault;

  always_comb
  begin
    sleep_next = !en_s || !vdd_ok_s;
    cmd_next = cmd_reg;
    // The rising chip-select edge is judged once both copies disagree.
    if (sleep_next)
      cmd_next = CMD_WORD_RESET;
    else if (cs_n_s && !cs_seen_reg && frame_ok(pulse_count))
      cmd_next = rx_word;
    drive = cmd_reg[7:0];
    drive[CH5_IDX] = cmd_reg[CH5_IDX] | dd5_s2;
    drive[CH6_IDX] = cmd_reg[CH6_IDX] | dd6_s2;
    // Over-voltage gating uses only the power supply sense; nothing watches for logic supply over-voltage.
    if (ov_s || sleep_reg)
      on_next = CMD_RESET;
    else
      on_next = drive & ~thermal_limit_s;
    det_next = sleep_reg ? CMD_RESET : cmd_reg[15:8];
    fault = thermal_limit_s | oc_s | (ol_s & ~drive & cmd_reg[15:8]);
    fault_word_next = {STATUS_PAD, fault};
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      cmd_reg <= CMD_WORD_RESET;
      sleep_reg <= 1'b1;
      on_reg <= CMD_RESET;
      det_reg <= CMD_RESET;
      fault_word_reg <= 16'h0000;
      cs_seen_reg <= 1'b1;
      out_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end
    else
    begin
      cmd_reg <= cmd_next;
      sleep_reg <= sleep_next;
      on_reg <= on_next;
      det_reg <= det_next;
      // Freeze status while a frame runs so the link reads a steady word.
      if (cs_n_s)
        fault_word_reg <= fault_word_next;
      cs_seen_reg <= cs_n_s;
      out_reg <= link_out;
      oe_n_reg <= link_oe_n;
    end
  end

  assign channel_on_out = on_reg;
  assign detect_current_on_out = det_reg;
  assign sleep_out = sleep_reg;
  assign serial_out = out_reg;
  assign serial_oe_n_out = oe_n_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_status_upper_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    fault_word_reg[15:8] == 8'h00) else $error("status high byte not zero");
  a_sleep_clears_cmd: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    sleep_next |=> cmd_reg == 16'h0000) else $error("sleep left command set");
  a_overvolt_all_off: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ov_s |=> on_reg == 8'h00) else $error("channel on during over-voltage");
  a_thermal_off: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    thermal_limit_s[0] |=> !on_reg[0]) else $error("hot channel left on");
  a_cmd_only_on_edge: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !cs_n_s |=> cmd_reg == $past(cmd_reg) || sleep_reg) else $error("command changed mid-frame");
  a_open_load_masked: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (cs_n_s && !cmd_reg[8] && !thermal_limit_s[0] && !oc_s[0]) |=> !fault_word_reg[0]) else $error("masked open load");
  a_bad_frame_drop: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (cs_n_s && !cs_seen_reg && !frame_ok(pulse_count) && !sleep_next) |=> $stable(cmd_reg))
    else $error("bad length frame applied");
  a_detect_follows: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !sleep_reg |=> det_reg == $past(cmd_reg[15:8])) else $error("detect current mismatch");
  a_sleep_outputs_off: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    sleep_reg |=> on_reg == 8'h00 && det_reg == 8'h00) else $error("output active in sleep");
  a_direct_drive_ch5: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (dd5_s2 && !ov_s && !sleep_reg && !thermal_limit_s[CH5_IDX]) |=> on_reg[CH5_IDX]) else $error("direct drive ignored");
  a_overcurrent_flag: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (cs_n_s && oc_s[0]) |=> fault_word_reg[0]) else $error("over-current not flagged");
endmodule // switch_ctrl_top

// file: switch_ctrl_pkg.sv
/*
  Constants shared by the octal switch serial control block.
  Assumes a single fast system clock and a host-driven serial clock.
*/
package switch_ctrl_pkg;
  localparam int CHANNELS = 8;
  localparam int WORD_BITS = 16;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [15:0] CMD_WORD_RESET = 16'h0000;
  localparam logic [7:0] STATUS_PAD = 8'h00;
  localparam logic [5:0] MIN_PULSES = 6'h10;
  localparam logic [5:0] PULSE_LIMIT = 6'h3f;
  localparam int REF_CLK_MHZ = 200;
  localparam int FRAME_GAP_US = 300;
  localparam int FRAME_GAP_CYCLES = FRAME_GAP_US * REF_CLK_MHZ;
  localparam int CH5_IDX = 4;
  localparam int CH6_IDX = 5;
endpackage

// file: serial_shift_link.sv
/*
  Link-side shift logic, clocked by the host serial clock.
  Assumes the host keeps the serial clock low at every chip-select edge.
*/
`timescale 1ns/1ps
module serial_shift_link
(
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic serial_in,
  input wire logic [15:0] status_word_in,
  output logic serial_out,
  output logic serial_oe_n_out,
  output logic [15:0] rx_word_out,
  output logic [5:0] pulse_count_out
);
  import switch_ctrl_pkg::*;

  logic [15:0] shift_reg;
  logic [5:0] count_reg;
  logic out_reg;
  logic first_reg;

  // Marks the start of a frame. Word and count are not cleared at chip-select rise,
  // because the reference domain reads them only after that edge has been synchronised.
  always_ff @(negedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
      first_reg <= 1'b1;
    else
      first_reg <= 1'b0;
  end

  // Falling edge samples input; shift register runs FIFO so input emerges 16 clocks later.
  always_ff @(negedge sclk_in)
  begin
    if (!cs_n_in)
    begin
      if (first_reg)
      begin
        shift_reg <= {status_word_in[14:0], serial_in};
        count_reg <= 6'h01;
      end
      else
      begin
        shift_reg <= {shift_reg[14:0], serial_in};
        if (count_reg != PULSE_LIMIT)
          count_reg <= count_reg + 6'h01;
      end
    end
  end

  // Output advances on rising edge, MSB first; first bit is shown as chip select falls.
  always_ff @(posedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
      out_reg <= 1'b0;
    else if (first_reg)
      out_reg <= status_word_in[15];
    else
      out_reg <= shift_reg[15];
  end

  assign serial_out = first_reg ? status_word_in[15] : out_reg;
  assign serial_oe_n_out = cs_n_in;
  assign rx_word_out = shift_reg;
  assign pulse_count_out = count_reg;
endmodule // serial_shift_link

// file: spi_host_model.sv
/*
  Host serial master model driving the switch block's serial port.
  Assumes the caller leaves a gap between frames; the clock idles low.
*/
`timescale 1ns/1ps
module spi_host_model
(
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b0;
    mosi_out = 1'b0;
    // A short select pulse gives the link a clean frame marker before the first frame.
    #1 cs_n_out = 1'b1;
  end
  // MSB first; data changes mid-high so the falling edge sees it settled.
  task automatic xfer(input logic [55:0] tx, input int n, output logic [55:0] rx);
    rx = '0;
    cs_n_out = 1'b0;
    #62.5;
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk_out = 1'b1;
      #31.25 mosi_out = tx[i];
      #31.25 rx = {rx[54:0], miso_in};
      sclk_out = 1'b0;
      #62.5;
    end
    cs_n_out = 1'b1;
    // A released line must not keep showing the last bit.
    mosi_out = ~mosi_out;
  endtask
endmodule // spi_host_model

// file: test_switch_ctrl_top.sv
/*
  Self-checking bench for switch_ctrl_top with a host serial model.
  Assumes the design settles within 20 reference clocks of any input change.
*/
`timescale 1ns/1ps
module test_switch_ctrl_top;
  import switch_ctrl_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, vdd_ok = 1'b1, ov = 1'b0, dd5 = 1'b0, dd6 = 1'b0;
  logic [7:0] th = 8'h00, oc = 8'h00, ol = 8'h00, ch, det;
  logic sclk, cs_n, mosi, miso, oe_n, slp;
  logic [55:0] rx;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  int bad_len[3] = '{15, 17, 20};
  switch_ctrl_top dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n),
    .serial_in(mosi), .enable_in(en), .logic_supply_ok_in(vdd_ok), .supply_overvolt_level_in(ov),
    .direct_drive_ch5_in(dd5), .direct_drive_ch6_in(dd6), .thermal_limit_in(th), .overcurrent_in(oc),
    .open_load_in(ol), .serial_out(miso), .serial_oe_n_out(oe_n), .channel_on_out(ch),
    .detect_current_on_out(det), .sleep_out(slp));
  spi_host_model host_u (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The 300 us host gap is shortened: sensor levels are already held stable.
  task automatic frame(input logic [55:0] tx, input int n);
    host_u.xfer(tx, n, rx);
    w(400);
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    w(3);
    rst_n = 1'b1;
    w(10);
    chk({slp, det, ch}, 32'h0);
    chk(oe_n, 1'b1);
    frame(16'ha53c, 16);
    chk(rx[31:0], 32'h0);
    chk({det, ch}, 16'ha53c);
    ol = 8'hff;
    oc = 8'h04;
    w(20);
    frame(16'ha53c, 16);
    chk(rx[31:0], 32'h0085);
    ol = 8'h00;
    oc = 8'h00;
    th = 8'h08;
    w(20);
    chk(ch, 8'h34);
    frame(16'ha53c, 16);
    chk(rx[31:0], 32'h0008);
    th = 8'h00;
    w(20);
    chk(ch, 8'h3c);
    ov = 1'b1;
    w(20);
    chk(ch, 8'h00);
    ov = 1'b0;
    w(20);
    chk(ch, 8'h3c);
    frame(16'ha50f, 16);
    dd5 = 1'b1;
    dd6 = 1'b1;
    w(20);
    chk(ch, 8'h3f);
    dd5 = 1'b0;
    dd6 = 1'b0;
    w(20);
    chk(ch, 8'h0f);
    foreach (bad_len[i])
    begin
      frame(56'hff00, bad_len[i]);
      chk({det, ch}, 16'ha50f);
    end
    frame({16'h1234, 16'h00f0}, 32);
    chk(rx[31:0], 32'h00001234);
    chk({det, ch}, 16'h00f0);
    frame({8'hab, 16'h5a0f}, 24);
    chk(rx[31:0], 32'h000000ab);
    chk({det, ch}, 16'h5a0f);
    for (int k = 0; k < 2; k++)
    begin
      frame(16'hffff, 16);
      if (k == 0)
        en = 1'b0;
      else
        vdd_ok = 1'b0;
      w(20);
      chk({slp, det, ch}, 32'h10000);
      en = 1'b1;
      vdd_ok = 1'b1;
      w(20);
      chk({slp, det, ch}, 32'h0);
    end
    print_verdict();
  end
endmodule // test_switch_ctrl_top
